//--- logic/pwst_ctrl.v
// pwm-to-adc trigger, supervision flags, fwd-voltage reference and ssc reset
// assumes pwm engine and adc status signals arrive on clock_in, no crossing
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pwst_consts.vh"

// Function
// - adc start comes (delay*2)+1 pwm clocks after each pwm period start
// - trigger arm only acts while the fwd-voltage reference enable is zero
// - software sets the arm bit; hardware clears it when the trigger fires
// - one trigger flag per colour; only software clears it
// - underrun flag sets when the trigger channel's pwm falls while adc is busy; sticky
// - overrun flag sets when adc runs past the pwm period; sticky
// - zero flag set by hardware on zero event; software clears it
// - each interrupt source requests only when its enable bit is set
// - reference enable drives the high-voltage output control, gates the turn-on pulse and blocks the trigger
// - hold flag sets when red pwm rises during temperature measurement
// - reference turn-on starts when pwm counter equals (setup+1)*16
// - ssc reset after (period+1) pwm periods and on pwm enable rising
// - spread spectrum modulation only while its enable bit is set
module pwst_ctrl (
	input wire clock_in,
	input wire rst_n_in,
	input wire [17:0] s_axi_awaddr_in,
	input wire s_axi_awvalid_in,
	output reg s_axi_awready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output reg s_axi_wready_out,
	output reg [1:0] s_axi_bresp_out,
	output reg s_axi_bvalid_out,
	input wire s_axi_bready_in,
	input wire [17:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	output reg s_axi_arready_out,
	output reg [31:0] s_axi_rdata_out,
	output reg [1:0] s_axi_rresp_out,
	output reg s_axi_rvalid_out,
	input wire s_axi_rready_in,
	input wire pwm_enable_in,
	input wire pwm_period_start_in,
	input wire [3:0] pwm_level_in,
	input wire [15:0] pwm_counter_in,
	input wire converter_busy_in,
	input wire zero_event_in,
	input wire temp_meas_in,
	output reg adc_start_out,
	output reg fwd_ref_turn_on_out,
	output reg fwd_ref_hv_ctrl_out,
	output reg ssc_reset_out,
	output reg ssc_active_out,
	output reg irq_out
);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function hit;
		input [17:0] addr;
		input [15:0] idx;
		begin
			hit = (addr[17:2] == idx) && (addr[1:0] == 2'h0);
		end
	endfunction

	function mapped;
		input [17:0] addr;
		begin
			mapped = hit(addr, `PWST_IDX_TRG_DELAY) ||
				hit(addr, `PWST_IDX_IRQ_CTRL) ||
				hit(addr, `PWST_IDX_IRQ_FLAGS) ||
				hit(addr, `PWST_IDX_FVR_CFG) ||
				hit(addr, `PWST_IDX_SSC_CFG) ||
				hit(addr, `PWST_IDX_IRQ_STATUS) ||
				hit(addr, `PWST_IDX_IRQ_MASK);
		end
	endfunction

	reg [7:0] trg_delay_reg;
	reg [7:0] ctrl_reg;
	reg [7:0] flags_reg;
	reg [7:0] fvr_cfg_reg;
	reg [7:0] ssc_cfg_reg;
	reg [4:0] ev_status_reg;
	reg [4:0] ev_mask_reg;

	// ----------------------------------------------------------------
	// axi4-lite slave
	// ----------------------------------------------------------------
	reg aw_have_reg;
	reg w_have_reg;
	reg [17:0] wr_addr_reg;
	reg [7:0] wr_data_reg;
	reg wr_lane_reg;
	wire wr_fire;
	wire rd_fire;
	reg [31:0] rd_mux;

	assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid_out;
	assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;

	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out <= 1'b1;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `PWST_RESP_OKAY;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			wr_addr_reg <= 18'h00000;
			wr_data_reg <= `PWST_RST_BYTE;
			wr_lane_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_have_reg <= 1'b1;
				wr_addr_reg <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_have_reg <= 1'b1;
				wr_data_reg <= s_axi_wdata_in[7:0];
				wr_lane_reg <= s_axi_wstrb_in[0];
				s_axi_wready_out <= 1'b0;
			end
			if (wr_fire) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				if (mapped(wr_addr_reg))
					s_axi_bresp_out <= `PWST_RESP_OKAY;
				else
					s_axi_bresp_out <= `PWST_RESP_SLVERR;
			end
			if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out <= 1'b1;
			end
		end
	end

	// only byte lane 0 carries register data; other lanes are ignored
	wire wr_ok;
	assign wr_ok = wr_fire && wr_lane_reg;

	always @* begin
		rd_mux = 32'h00000000;
		if (hit(s_axi_araddr_in, `PWST_IDX_TRG_DELAY))
			rd_mux[7:0] = trg_delay_reg;
		else if (hit(s_axi_araddr_in, `PWST_IDX_IRQ_CTRL))
			rd_mux[7:0] = ctrl_reg;
		else if (hit(s_axi_araddr_in, `PWST_IDX_IRQ_FLAGS))
			rd_mux[7:0] = {flags_reg[7:4], converter_busy_in,
				flags_reg[2:0]};
		else if (hit(s_axi_araddr_in, `PWST_IDX_FVR_CFG))
			rd_mux[7:0] = fvr_cfg_reg;
		else if (hit(s_axi_araddr_in, `PWST_IDX_SSC_CFG))
			rd_mux[7:0] = {4'h0, ssc_cfg_reg[3:0]};
		else if (hit(s_axi_araddr_in, `PWST_IDX_IRQ_STATUS))
			rd_mux[4:0] = ev_status_reg;
		else if (hit(s_axi_araddr_in, `PWST_IDX_IRQ_MASK))
			rd_mux[4:0] = ev_mask_reg;
	end

	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= `PWST_RESP_OKAY;
		end else begin
			if (rd_fire) begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out <= rd_mux;
				if (mapped(s_axi_araddr_in))
					s_axi_rresp_out <= `PWST_RESP_OKAY;
				else
					s_axi_rresp_out <= `PWST_RESP_SLVERR;
			end else if (s_axi_rvalid_out && s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
				s_axi_arready_out <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// pwm clock enable and edge history
	// ----------------------------------------------------------------
	reg [7:0] div_cnt_reg;
	reg pwm_tick_reg;
	reg [3:0] lvl_prev_reg;
	reg en_prev_reg;
	reg turn_match_prev_reg;

	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_cnt_reg <= 8'h00;
			pwm_tick_reg <= 1'b0;
			lvl_prev_reg <= 4'h0;
			en_prev_reg <= 1'b0;
		end else begin
			lvl_prev_reg <= pwm_level_in;
			en_prev_reg <= pwm_enable_in;
			if (div_cnt_reg == `PWST_PWM_DIV - 8'h01) begin
				div_cnt_reg <= 8'h00;
				pwm_tick_reg <= 1'b1;
			end else begin
				div_cnt_reg <= div_cnt_reg + 8'h01;
				pwm_tick_reg <= 1'b0;
			end
		end
	end

	wire en_rise;
	wire [3:0] lvl_fall;
	wire [3:0] lvl_rise;
	assign en_rise = pwm_enable_in && !en_prev_reg;
	assign lvl_fall = lvl_prev_reg & ~pwm_level_in;
	assign lvl_rise = ~lvl_prev_reg & pwm_level_in;

	// ----------------------------------------------------------------
	// adc start delay and one-shot trigger
	// ----------------------------------------------------------------
	reg [8:0] dly_cnt_reg;
	reg dly_run_reg;
	wire adc_fire;
	wire fvr_en;
	wire trig_fire;
	reg [3:0] ch_onehot;

	assign adc_fire = dly_run_reg && pwm_tick_reg && (dly_cnt_reg == 9'h001);
	assign fvr_en = fvr_cfg_reg[`PWST_FVR_EN];
	assign trig_fire = adc_fire && ctrl_reg[`PWST_CTL_ARM] && !fvr_en;

	always @* begin
		case (ctrl_reg[`PWST_CTL_CHSEL_HI:`PWST_CTL_CHSEL_LO])
		2'h0: ch_onehot = 4'h1;
		2'h1: ch_onehot = 4'h2;
		2'h2: ch_onehot = 4'h4;
		default: ch_onehot = 4'h8;
		endcase
	end

	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dly_cnt_reg <= 9'h000;
			dly_run_reg <= 1'b0;
			adc_start_out <= 1'b0;
		end else begin
			adc_start_out <= adc_fire;
			if (pwm_period_start_in && pwm_enable_in) begin
				dly_cnt_reg <= {trg_delay_reg, 1'b1};
				dly_run_reg <= 1'b1;
			end else if (dly_run_reg && pwm_tick_reg) begin
				dly_cnt_reg <= dly_cnt_reg - 9'h001;
				if (dly_cnt_reg == 9'h001)
					dly_run_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// software registers and sticky flags
	// ----------------------------------------------------------------
	wire [7:0] flag_set;
	wire [7:0] flag_clr;
	wire hold_set;
	wire under_set;
	wire over_set;
	wire [4:0] ev_set;
	wire [4:0] ev_en;

	// underrun watches the channel the trigger is set to
	assign under_set = |(lvl_fall & ch_onehot) && converter_busy_in;
	assign over_set = pwm_period_start_in && converter_busy_in;
	assign hold_set = lvl_rise[0] && temp_meas_in;
	// white, blue, green, red from bit 7 down
	assign flag_set = {trig_fire ? {ch_onehot[3], ch_onehot[2],
		ch_onehot[1], ch_onehot[0]} : 4'h0,
		1'b0, under_set, over_set, zero_event_in};
	// writing zero clears a flag, writing one leaves it
	assign flag_clr = (wr_ok && hit(wr_addr_reg, `PWST_IDX_IRQ_FLAGS)) ?
		~wr_data_reg : 8'h00;
	assign ev_set = {hold_set, trig_fire, under_set, over_set,
		zero_event_in};
	assign ev_en = ctrl_reg[`PWST_CTL_EN_HI:0];

	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			trg_delay_reg <= `PWST_RST_BYTE;
			ctrl_reg <= `PWST_RST_BYTE;
			flags_reg <= `PWST_RST_BYTE;
			fvr_cfg_reg <= `PWST_RST_BYTE;
			ssc_cfg_reg <= `PWST_RST_BYTE;
			ev_status_reg <= `PWST_RST_EV;
			ev_mask_reg <= `PWST_RST_EV;
		end else begin
			if (wr_ok && hit(wr_addr_reg, `PWST_IDX_TRG_DELAY))
				trg_delay_reg <= wr_data_reg;
			if (wr_ok && hit(wr_addr_reg, `PWST_IDX_IRQ_CTRL))
				ctrl_reg <= wr_data_reg;
			else if (trig_fire)
				ctrl_reg[`PWST_CTL_ARM] <= 1'b0;
			// set wins over a clear in the same cycle
			flags_reg <= (flags_reg & ~flag_clr) | flag_set;
			flags_reg[`PWST_FLG_BUSY] <= 1'b0;
			if (wr_ok && hit(wr_addr_reg, `PWST_IDX_FVR_CFG)) begin
				fvr_cfg_reg[`PWST_FVR_EN] <= wr_data_reg[`PWST_FVR_EN];
				fvr_cfg_reg[5:0] <= wr_data_reg[5:0];
				fvr_cfg_reg[`PWST_FVR_HOLD] <= hold_set ||
					(fvr_cfg_reg[`PWST_FVR_HOLD] &&
					wr_data_reg[`PWST_FVR_HOLD]);
			end else if (hold_set) begin
				fvr_cfg_reg[`PWST_FVR_HOLD] <= 1'b1;
			end
			if (wr_ok && hit(wr_addr_reg, `PWST_IDX_SSC_CFG))
				ssc_cfg_reg <= {4'h0, wr_data_reg[3:0]};
			if (wr_ok && hit(wr_addr_reg, `PWST_IDX_IRQ_MASK))
				ev_mask_reg <= wr_data_reg[4:0];
			// a read clears status, but an event in that cycle survives
			if (rd_fire && hit(s_axi_araddr_in, `PWST_IDX_IRQ_STATUS))
				ev_status_reg <= ev_set;
			else
				ev_status_reg <= ev_status_reg | ev_set;
		end
	end

	// ----------------------------------------------------------------
	// fwd-voltage reference, ssc and interrupt outputs
	// ----------------------------------------------------------------
	reg [2:0] ssc_per_cnt_reg;
	wire [10:0] turn_point;
	wire turn_match;

	assign turn_point = {1'b0, fvr_cfg_reg[5:0], 4'h0} + 11'h010;
	assign turn_match = (pwm_counter_in == {5'h00, turn_point});

	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			turn_match_prev_reg <= 1'b0;
			fwd_ref_turn_on_out <= 1'b0;
			fwd_ref_hv_ctrl_out <= 1'b0;
			ssc_per_cnt_reg <= 3'h0;
			ssc_reset_out <= 1'b0;
			ssc_active_out <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			turn_match_prev_reg <= turn_match;
			// one pulse per arrival, the counter may dwell on the value
			fwd_ref_turn_on_out <= fvr_en && turn_match &&
				!turn_match_prev_reg;
			fwd_ref_hv_ctrl_out <= fvr_en;
			ssc_active_out <= ssc_cfg_reg[`PWST_SSC_EN] &&
				pwm_enable_in;
			ssc_reset_out <= 1'b0;
			if (en_rise) begin
				ssc_per_cnt_reg <= 3'h0;
				ssc_reset_out <= 1'b1;
			end else if (pwm_period_start_in && pwm_enable_in) begin
				if (ssc_per_cnt_reg == ssc_cfg_reg[2:0]) begin
					ssc_per_cnt_reg <= 3'h0;
					ssc_reset_out <= 1'b1;
				end else begin
					ssc_per_cnt_reg <= ssc_per_cnt_reg + 3'h1;
				end
			end
			irq_out <= |(ev_status_reg & ev_mask_reg & ev_en);
		end
	end

endmodule
`default_nettype wire

//--- logic/pwst_consts.vh
// constants for the pwm adc trigger and supervision block
// assumes a 32-bit axi4-lite slave with word-aligned registers
`ifndef PWST_CONSTS_VH
`define PWST_CONSTS_VH

// register indices, byte address is four times the index
`define PWST_IDX_TRG_DELAY 16'ha08c
`define PWST_IDX_IRQ_CTRL 16'ha08d
`define PWST_IDX_IRQ_FLAGS 16'ha08f
`define PWST_IDX_FVR_CFG 16'ha09e
`define PWST_IDX_SSC_CFG 16'ha09f
`define PWST_IDX_IRQ_STATUS 16'ha0a0
`define PWST_IDX_IRQ_MASK 16'ha0a1

// pwm_irq_control fields
`define PWST_CTL_ARM 7
`define PWST_CTL_CHSEL_HI 6
`define PWST_CTL_CHSEL_LO 5
`define PWST_CTL_EN_HI 4

// pwm_irq_flags fields
`define PWST_FLG_BUSY 3
`define PWST_FLG_UNDER 2
`define PWST_FLG_OVER 1
`define PWST_FLG_ZERO 0

// fwd_voltage_ref_config fields
`define PWST_FVR_EN 7
`define PWST_FVR_HOLD 6

// spread_spectrum_config fields
`define PWST_SSC_EN 3

// interrupt status / mask bit order
`define PWST_EV_HOLD 4
`define PWST_EV_TRIG 3
`define PWST_EV_UNDER 2
`define PWST_EV_OVER 1
`define PWST_EV_ZERO 0

// reset values
`define PWST_RST_BYTE 8'h00
`define PWST_RST_EV 5'h00

// pwm clock enable divider, system clocks per pwm clock
`define PWST_PWM_DIV 8'h02

// axi responses
`define PWST_RESP_OKAY 2'h0
`define PWST_RESP_SLVERR 2'h2

`endif

//--- tb/pwst_ctrl_sva.sv
// checker for the pwm trigger and supervision block, top-level ports only
// assumes a single clock domain and the design header on the include path
`timescale 1ns/1ps
`default_nettype none
module pwst_ctrl_sva (
	input wire clock_in,
	input wire rst_n_in,
	input wire s_axi_awvalid_in,
	input wire s_axi_awready_out,
	input wire s_axi_wvalid_in,
	input wire s_axi_wready_out,
	input wire s_axi_bvalid_out,
	input wire s_axi_arvalid_in,
	input wire s_axi_arready_out,
	input wire s_axi_rvalid_out,
	input wire pwm_enable_in,
	input wire [15:0] pwm_counter_in,
	input wire adc_start_out,
	input wire fwd_ref_turn_on_out,
	input wire ssc_reset_out,
	input wire ssc_active_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	// ----------------------------------------
	// pulses and their causes
	// ----------------------------------------
	start_pulse_a: assert property (adc_start_out |=> !adc_start_out)
		else $error("adc start wider than one cycle");
	turnon_pulse_a: assert property (fwd_ref_turn_on_out |=>
		!fwd_ref_turn_on_out)
		else $error("turn-on wider than one cycle");
	turnon_cause_a: assert property (fwd_ref_turn_on_out |->
		$past(pwm_counter_in[3:0]) == 4'h0 && $past(pwm_counter_in) != 16'h0)
		else $error("turn-on at a count that is no multiple of 16");
	ssc_rise_a: assert property ($rose(pwm_enable_in) |=> ssc_reset_out)
		else $error("no ssc reset after enable rising");
	ssc_active_a: assert property (ssc_active_out |->
		$past(pwm_enable_in))
		else $error("ssc active while pwm disabled");
	// ----------------------------------------
	// register bus timing
	// ----------------------------------------
	read_lat_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
		s_axi_rvalid_out)
		else $error("read answer late");
	write_lat_a: assert property (s_axi_awvalid_in && s_axi_awready_out &&
		s_axi_wvalid_in && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out)
		else $error("write answer late");
	read_stand_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("new read accepted during answer");
	cover property (adc_start_out);
	cover property (fwd_ref_turn_on_out);
	cover property (ssc_reset_out);
endmodule
bind pwst_ctrl pwst_ctrl_sva pwst_ctrl_sva_inst (.*);
`default_nettype wire

//--- tb/pwst_ctrl_bench.sv
// self-checking bench for the pwm trigger and supervision block
// assumes the design header pwst_consts.vh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "pwst_consts.vh"
module pwst_ctrl_bench;
	logic clock_in = 0, rst_n_in = 0;
	logic [17:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd, fx;
	logic [3:0] s_axi_wstrb_in, pwm_level_in;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rs;
	logic [15:0] pwm_counter_in;
	logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
	logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
	logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out;
	logic s_axi_rready_in, pwm_enable_in, pwm_period_start_in;
	logic converter_busy_in, zero_event_in, temp_meas_in, adc_start_out;
	logic fwd_ref_turn_on_out, fwd_ref_hv_ctrl_out, ssc_reset_out;
	logic ssc_active_out, irq_out;
	logic [7:0] d, s, p;
	int n_fail = 0, checked = 0, n, ch, nres;
	logic [15:0] regs [7] = '{`PWST_IDX_TRG_DELAY, `PWST_IDX_IRQ_CTRL,
		`PWST_IDX_IRQ_FLAGS, `PWST_IDX_FVR_CFG, `PWST_IDX_SSC_CFG,
		`PWST_IDX_IRQ_STATUS, `PWST_IDX_IRQ_MASK};
	pwst_ctrl pwst_ctrl_inst (.*);
	always #25 clock_in = ~clock_in;
	always @(posedge clock_in) if (ssc_reset_out) nres++;
	// expected read response: okay for a mapped index, slave error otherwise
	function automatic logic [1:0] rsp(input logic [15:0] idx);
		rsp = 2'h2;
		foreach (regs[i]) if (regs[i] == idx) rsp = 2'h0;
	endfunction
	// ----------------------------------------
	// bus tasks and comparison
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task summarize;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task tmo;
		n_fail++;
		summarize();
	endtask
	task automatic wr(input logic [15:0] idx, input logic [7:0] v,
		input logic [1:0] er);
		@(posedge clock_in);
		s_axi_awaddr_in <= {idx, 2'b00};
		s_axi_wdata_in <= {24'h0, v};
		s_axi_awvalid_in <= 1;
		s_axi_wvalid_in <= 1;
		s_axi_bready_in <= 1;
		for (n = 0; n < 40; n++) begin
			@(posedge clock_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 0;
			if (s_axi_bvalid_out) break;
		end
		s_axi_bready_in <= 0;
		if (n == 40) tmo();
		chk(s_axi_bresp_out, er);
	endtask
	task automatic rc(input logic [15:0] idx, input logic [31:0] e);
		@(posedge clock_in);
		s_axi_araddr_in <= {idx, 2'b00};
		s_axi_arvalid_in <= 1;
		s_axi_rready_in <= 1;
		for (n = 0; n < 40; n++) begin
			@(posedge clock_in);
			if (s_axi_arready_out) s_axi_arvalid_in <= 0;
			if (s_axi_rvalid_out) break;
		end
		rs = s_axi_rresp_out;
		s_axi_rready_in <= 0;
		if (n == 40) tmo();
		chk(s_axi_rdata_out, e);
		chk({30'h0, rs}, {30'h0, rsp(idx)});
	endtask
	task cyc(input int k);
		repeat (k) @(posedge clock_in);
	endtask
	task ps;
		pwm_period_start_in <= 1;
		@(posedge clock_in);
		pwm_period_start_in <= 0;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, pwm_counter_in} = 0;
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 0;
		{s_axi_arvalid_in, s_axi_rready_in, pwm_enable_in, pwm_level_in} = 0;
		{pwm_period_start_in, converter_busy_in, zero_event_in} = 0;
		temp_meas_in = 0;
		s_axi_wstrb_in = 4'h1;
		void'($urandom(25));
		cyc(2);
		rst_n_in <= 1;
		foreach (regs[i]) rc(regs[i], 32'h0);
		rc(16'ha0b0, 32'h0);
		wr(16'ha0b0, 8'hff, 2'h2);
		repeat (4) begin
			d = $urandom;
			wr(`PWST_IDX_TRG_DELAY, d, 2'h0);
			rc(`PWST_IDX_TRG_DELAY, {24'h0, d});
		end
		wr(`PWST_IDX_IRQ_MASK, 8'h1f, 2'h0);
		pwm_enable_in <= 1;
		fx = 0;
		for (ch = 0; ch < 4; ch++) begin
			d = $urandom_range(5);
			wr(`PWST_IDX_TRG_DELAY, d, 2'h0);
			wr(`PWST_IDX_IRQ_CTRL, {1'b1, ch[1:0], 5'h08}, 2'h0);
			ps();
			for (n = 0; n < 2000; n++) begin
				@(posedge clock_in);
				if (adc_start_out) break;
			end
			chk(n >= 4 * d + 1 && n <= 4 * d + 4, 1);
			cyc(2);
			chk(irq_out, 1);
			fx[4 + ch] = 1;
			rc(`PWST_IDX_IRQ_FLAGS, fx);
			rc(`PWST_IDX_IRQ_CTRL, {ch[1:0], 5'h08});
			rc(`PWST_IDX_IRQ_STATUS, 32'h08);
			cyc(2);
			chk(irq_out, 0);
		end
		wr(`PWST_IDX_IRQ_FLAGS, 8'h0, 2'h0);
		s = $urandom_range(63);
		wr(`PWST_IDX_FVR_CFG, {2'b10, s[5:0]}, 2'h0);
		wr(`PWST_IDX_IRQ_CTRL, 8'h80, 2'h0);
		ps();
		cyc(40);
		rc(`PWST_IDX_IRQ_CTRL, 32'h80);
		rc(`PWST_IDX_IRQ_FLAGS, 32'h0);
		chk(fwd_ref_hv_ctrl_out, 1);
		pwm_counter_in <= (s + 16'h1) * 16'h10;
		@(posedge clock_in);
		pwm_counter_in <= 0;
		@(posedge clock_in);
		chk(fwd_ref_turn_on_out, 1);
		temp_meas_in <= 1;
		pwm_level_in <= 4'h1;
		cyc(2);
		temp_meas_in <= 0;
		converter_busy_in <= 1;
		@(posedge clock_in);
		pwm_level_in <= 4'h0;
		zero_event_in <= 1;
		ps();
		zero_event_in <= 0;
		cyc(2);
		rc(`PWST_IDX_FVR_CFG, {2'b11, s[5:0]});
		rc(`PWST_IDX_IRQ_FLAGS, 32'h0f);
		chk(irq_out, 0);
		wr(`PWST_IDX_IRQ_CTRL, 8'h07, 2'h0);
		cyc(2);
		chk(irq_out, 1);
		converter_busy_in <= 0;
		cyc(20);
		rc(`PWST_IDX_IRQ_FLAGS, 32'h07);
		wr(`PWST_IDX_IRQ_FLAGS, 8'h0, 2'h0);
		rc(`PWST_IDX_IRQ_FLAGS, 32'h0);
		// enable toggles first so the period count restarts from a known place
		p = $urandom_range(7);
		wr(`PWST_IDX_SSC_CFG, 8'h08 | p, 2'h0);
		pwm_enable_in <= 0;
		cyc(3);
		chk(ssc_active_out, 0);
		nres = 0;
		pwm_enable_in <= 1;
		cyc(3);
		repeat (2 * (p + 1)) begin
			ps();
			cyc(30);
		end
		chk(nres, 3);
		chk(ssc_active_out, 1);
		wr(`PWST_IDX_SSC_CFG, p, 2'h0);
		cyc(3);
		chk(ssc_active_out, 0);
		summarize();
	end
	initial begin
		#2500000;
		tmo();
	end
endmodule
`default_nettype wire
